// >>> design/mfr_defs.svh
`ifndef MFR_DEFS_SVH
`define MFR_DEFS_SVH
// opcodes
`define MFR_OP_OUT4_NARROW 8'h6B
`define MFR_OP_OUT4_WIDE 8'h6C
`define MFR_OP_DIO3 8'hBB
`define MFR_OP_DIO4 8'hBC
`define MFR_OP_QIO3 8'hEB
`define MFR_OP_QIO4 8'hEC
`define MFR_OP_MODE_RST 8'hFF
// mode upper nibble that keeps continuous read
`define MFR_MODE_KEEP 4'hA
// config bit positions
`define MFR_CR2_ADDR_LEN 0
`define MFR_CR2_QUAD_CMD 1
`define MFR_CR2_QUAD_INSTR 3
`define MFR_CR1_QUAD 1
// mode phase lengths in link clocks, then phase counter width in bits
`define MFR_DIO_MODE_CYC 4
`define MFR_QIO_MODE_CYC 2
`define MFR_CNT_W 6
// all-ones clocks that make the mode reset command
`define MFR_MRST_CLKS 8
`define MFR_MRST_CLKS_QI 2
`endif

// >>> design/mfr_pkg.sv
package mfr_pkg;
   typedef enum logic [1:0] {
      MFR_CMD_NONE,
      MFR_CMD_OUT4,
      MFR_CMD_DIO,
      MFR_CMD_QIO
   } mfr_cmd_t;
   typedef enum logic [2:0] {
      MFR_ST_IDLE,
      MFR_ST_INSTR,
      MFR_ST_ADDR,
      MFR_ST_MODE,
      MFR_ST_DUMMY,
      MFR_ST_DATA,
      MFR_ST_IGNORE
   } mfr_state_t;
endpackage

// >>> design/mfr_sync.sv
`timescale 1ns/1ps
module mfr_sync #(
   parameter int W = 1
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);
   logic [W-1:0] meta_reg;
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta_reg <= '0;
         o_q <= '0;
      end else begin
         meta_reg <= i_d;
         o_q <= meta_reg;
      end
   end
endmodule

// >>> design/mfr_mem.sv
`timescale 1ns/1ps
module mfr_mem #(
   parameter int AW = 8
) (
   input wire logic i_clk,
   input wire logic [AW-1:0] i_waddr,
   input wire logic [7:0] i_wdata,
   input wire logic i_we,
   input wire logic [AW-1:0] i_raddr,
   output logic [7:0] o_rdata
);
   logic [7:0] mem [0:(1<<AW)-1];
   always_ff @(posedge i_clk) begin
      if (i_we) begin
         mem[i_waddr] <= i_wdata;
      end
      o_rdata <= mem[i_raddr];
   end
endmodule

// >>> design/mfr_read_engine.sv
`timescale 1ns/1ps
// Summary of operation
// - 6Bh address length by bit; 6Ch four bytes
// - output read dummy count from latency code
// - output read address on line zero only
// - dummy cycles ignore all four lines
// - output read nibble per falling edge
// - address increments per byte, wraps zero
// - BBh length by bit; BCh four bytes
// - instruction, two-bit address, four mode clocks
// - two-line latency after mode, inputs ignored
// - two-line data on lines zero, one
// - mode Ah keeps two-line continuous read
// - only mode upper nibble decoded
// - other mode leaves continuous at deselect
// - mode reset command leaves continuous read
// - EBh length by bit; ECh four bytes
// - four-line read needs quad enable or quad command bit
// - nibble address, two mode clocks, dummy, data
// - mode Ah keeps four-line continuous read
// - four-wire mode: instruction four bits/clock
// - address msb 23 or 31
// - dummy counted falling to falling edge
// - select high ends any read
// - address-length bit widens traditional commands
module mfr_read_engine
   import mfr_pkg::*;
#(
   parameter int MEM_AW = 8
) (
   // system
   input wire logic i_clk,
   input wire logic i_rst_n,
   // link pins
   input wire logic i_sck,
   input wire logic i_cs_n,
   input wire logic [3:0] i_io,
   output logic [3:0] o_io,
   output logic [3:0] o_io_oe_n,
   // configuration
   input wire logic [3:0] i_latency_config_reg,
   input wire logic [7:0] i_config_reg1_volatile,
   input wire logic [7:0] i_config_reg2_volatile,
   // memory preload
   input wire logic i_mem_we,
   input wire logic [MEM_AW-1:0] i_mem_waddr,
   input wire logic [7:0] i_mem_wdata,
   // status
   output logic o_cont_active,
   output logic o_busy
);
`include "mfr_defs.svh"

   logic sck_s, cs_n_s;
   logic [3:0] io_s;
   mfr_sync #(.W(6)) u_sync (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_d({i_sck, i_cs_n, i_io}),
      .o_q({sck_s, cs_n_s, io_s})
   );

   logic sck_d_reg, cs_d_reg;
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sck_d_reg <= 1'b0;
         cs_d_reg <= 1'b1;
      end else begin
         sck_d_reg <= sck_s;
         cs_d_reg <= cs_n_s;
      end
   end
   wire sck_rise = sck_s && !sck_d_reg && !cs_n_s;
   wire sck_fall = !sck_s && sck_d_reg && !cs_n_s;
   wire cs_rise = cs_n_s && !cs_d_reg;

   mfr_state_t state_reg;
   mfr_cmd_t cmd_reg, cont_cmd_reg;
   logic [`MFR_CNT_W-1:0] cnt_reg;
   logic [7:0] shift_reg;
   logic [31:0] addr_reg;
   logic wide_reg;
   logic [3:0] mode_hi_reg;
   logic keep_reg;
   logic [2:0] bitpos_reg;
   logic [7:0] rdata;
   logic [3:0] ones_cnt_reg;
   logic ones_dead_reg;
   // first data nibble leaves on the fall that ends the last dummy
   wire data_fall = sck_fall && (state_reg == MFR_ST_DATA || (state_reg == MFR_ST_DUMMY && cnt_reg == '0));

   wire addr_len = i_config_reg2_volatile[`MFR_CR2_ADDR_LEN];
   wire quad_instr = i_config_reg2_volatile[`MFR_CR2_QUAD_INSTR];
   wire quad_ok = i_config_reg1_volatile[`MFR_CR1_QUAD] | i_config_reg2_volatile[`MFR_CR2_QUAD_CMD];
   wire ones_bit = quad_instr ? (&io_s) : io_s[0];
   wire mrst_hit = sck_rise && !ones_dead_reg && ones_bit
                   && ones_cnt_reg == (quad_instr ? 4'(`MFR_MRST_CLKS_QI - 1) : 4'(`MFR_MRST_CLKS - 1));

   // lines per clock for the current address phase
   function automatic logic [2:0] addr_lanes(input mfr_cmd_t c);
      case (c)
         MFR_CMD_OUT4: addr_lanes = 3'd1;
         MFR_CMD_DIO: addr_lanes = 3'd2;
         MFR_CMD_QIO: addr_lanes = 3'd4;
         default: addr_lanes = 3'd1;
      endcase
   endfunction

   // clocks for the address phase
   function automatic logic [`MFR_CNT_W-1:0] addr_clks(input mfr_cmd_t c, input logic w);
      logic [5:0] bits;
      bits = w ? 6'd32 : 6'd24;
      case (c)
         MFR_CMD_DIO: addr_clks = bits >> 1;
         MFR_CMD_QIO: addr_clks = bits >> 2;
         default: addr_clks = bits;
      endcase
   endfunction

   logic [7:0] op_full;
   always_comb begin
      op_full = quad_instr ? {shift_reg[3:0], io_s} : {shift_reg[6:0], io_s[0]};
   end

   // byte-step address wrapping at the top of the array
   mfr_mem #(.AW(MEM_AW)) u_mem (
      .i_clk(i_clk),
      .i_waddr(i_mem_waddr),
      .i_wdata(i_mem_wdata),
      .i_we(i_mem_we),
      .i_raddr(addr_reg[MEM_AW-1:0]),
      .o_rdata(rdata)
   );

   // command sequencer
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_reg <= MFR_ST_IDLE;
         cmd_reg <= MFR_CMD_NONE;
         cnt_reg <= '0;
         shift_reg <= 8'h00;
         addr_reg <= 32'h0;
         wide_reg <= 1'b0;
         mode_hi_reg <= 4'h0;
         bitpos_reg <= 3'd7;
      end else if (cs_n_s) begin
         state_reg <= MFR_ST_IDLE;
         cnt_reg <= '0;
      end else begin
         case (state_reg)
            MFR_ST_IDLE: begin
               if (cont_cmd_reg != MFR_CMD_NONE) begin
                  cmd_reg <= cont_cmd_reg;
                  state_reg <= MFR_ST_ADDR;
                  cnt_reg <= addr_clks(cont_cmd_reg, wide_reg);
                  addr_reg <= 32'h0;
                  bitpos_reg <= 3'd7;
               end else begin
                  state_reg <= MFR_ST_INSTR;
                  bitpos_reg <= 3'd7;
                  cnt_reg <= quad_instr ? 6'd2 : 6'd8;
                  shift_reg <= 8'h00;
               end
            end
            MFR_ST_INSTR: if (sck_rise) begin
               shift_reg <= op_full;
               cnt_reg <= cnt_reg - 6'd1;
               if (cnt_reg == 6'd1) begin
                  state_reg <= MFR_ST_ADDR;
                  addr_reg <= 32'h0;
                  case (op_full)
                     `MFR_OP_OUT4_NARROW, `MFR_OP_OUT4_WIDE: begin
                        cmd_reg <= MFR_CMD_OUT4;
                        wide_reg <= addr_len || op_full == `MFR_OP_OUT4_WIDE;
                        cnt_reg <= addr_clks(MFR_CMD_OUT4, addr_len || op_full == `MFR_OP_OUT4_WIDE);
                     end
                     `MFR_OP_DIO3, `MFR_OP_DIO4: begin
                        cmd_reg <= MFR_CMD_DIO;
                        wide_reg <= addr_len || op_full == `MFR_OP_DIO4;
                        cnt_reg <= addr_clks(MFR_CMD_DIO, addr_len || op_full == `MFR_OP_DIO4);
                     end
                     `MFR_OP_QIO3, `MFR_OP_QIO4: begin
                        cmd_reg <= quad_ok ? MFR_CMD_QIO : MFR_CMD_NONE;
                        state_reg <= quad_ok ? MFR_ST_ADDR : MFR_ST_IGNORE;
                        wide_reg <= addr_len || op_full == `MFR_OP_QIO4;
                        cnt_reg <= addr_clks(MFR_CMD_QIO, addr_len || op_full == `MFR_OP_QIO4);
                     end
                     default: begin
                        cmd_reg <= MFR_CMD_NONE;
                        state_reg <= MFR_ST_IGNORE;
                     end
                  endcase
               end
            end
            MFR_ST_ADDR: if (sck_rise) begin
               cnt_reg <= cnt_reg - 6'd1;
               case (addr_lanes(cmd_reg))
                  3'd2: addr_reg <= {addr_reg[29:0], io_s[1:0]};
                  3'd4: addr_reg <= {addr_reg[27:0], io_s};
                  default: addr_reg <= {addr_reg[30:0], io_s[0]};
               endcase
               if (cnt_reg == 6'd1) begin
                  if (cmd_reg == MFR_CMD_OUT4) begin
                     state_reg <= MFR_ST_DUMMY;
                     cnt_reg <= {2'b00, i_latency_config_reg};
                  end else begin
                     state_reg <= MFR_ST_MODE;
                     cnt_reg <= (cmd_reg == MFR_CMD_DIO) ? 6'(`MFR_DIO_MODE_CYC) : 6'(`MFR_QIO_MODE_CYC);
                  end
               end
            end
            MFR_ST_MODE: if (sck_rise) begin
               cnt_reg <= cnt_reg - 6'd1;
               // upper nibble only; lower don't care
               if (cmd_reg == MFR_CMD_DIO && cnt_reg > 6'd2) begin
                  mode_hi_reg <= {mode_hi_reg[1:0], io_s[1:0]};
               end
               if (cmd_reg == MFR_CMD_QIO && cnt_reg == 6'd2) begin
                  mode_hi_reg <= io_s;
               end
               if (cnt_reg == 6'd1) begin
                  state_reg <= MFR_ST_DUMMY;
                  cnt_reg <= {2'b00, i_latency_config_reg};
               end
            end
            MFR_ST_DUMMY: begin
               // line inputs never sampled here
               if (sck_fall) begin
                  if (cnt_reg == '0) begin
                     state_reg <= MFR_ST_DATA;
                  end else begin
                     cnt_reg <= cnt_reg - 6'd1;
                  end
               end
            end
            MFR_ST_DATA: state_reg <= MFR_ST_DATA;
            MFR_ST_IGNORE: state_reg <= MFR_ST_IGNORE;
            default: state_reg <= MFR_ST_IDLE;
         endcase
         // lane position: 7,5,3,1 for two lines, 7,3 for four
         if (data_fall) begin
            bitpos_reg <= bitpos_reg - ((cmd_reg == MFR_CMD_DIO) ? 3'd2 : 3'd4);
            if (bitpos_reg == ((cmd_reg == MFR_CMD_DIO) ? 3'd1 : 3'd3)) begin
               addr_reg <= addr_reg + 32'h1;
            end
         end
      end
   end

   // mode reset: all-ones clocks from frame start; in continuous mode
   // they land in the address slot, so an all-ones top address aliases it
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ones_cnt_reg <= 4'h0;
         ones_dead_reg <= 1'b0;
      end else if (cs_n_s) begin
         ones_cnt_reg <= 4'h0;
         ones_dead_reg <= 1'b0;
      end else if (sck_rise && !ones_dead_reg && ones_cnt_reg != 4'hF) begin
         if (ones_bit) begin
            ones_cnt_reg <= ones_cnt_reg + 4'h1;
         end else begin
            ones_dead_reg <= 1'b1;
         end
      end
   end

   // continuous mode: decided at deselect from captured mode
   assign keep_reg = (mode_hi_reg == `MFR_MODE_KEEP);
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cont_cmd_reg <= MFR_CMD_NONE;
      end else if (mrst_hit) begin
         cont_cmd_reg <= MFR_CMD_NONE;
      end else if (cs_rise && (cmd_reg == MFR_CMD_DIO || cmd_reg == MFR_CMD_QIO)
                   && (state_reg == MFR_ST_DUMMY || state_reg == MFR_ST_DATA)) begin
         cont_cmd_reg <= keep_reg ? cmd_reg : MFR_CMD_NONE;
      end
   end

   // output lanes, msb on highest line
   logic [3:0] out_next;
   always_comb begin
      out_next = 4'h0;
      if (cmd_reg == MFR_CMD_DIO) begin
         out_next = {2'b00, rdata[bitpos_reg], rdata[bitpos_reg-3'd1]};
      end else begin
         out_next = bitpos_reg[2] ? rdata[7:4] : rdata[3:0];
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_io <= 4'h0;
         o_io_oe_n <= 4'hF;
         o_cont_active <= 1'b0;
         o_busy <= 1'b0;
      end else begin
         o_cont_active <= (cont_cmd_reg != MFR_CMD_NONE);
         o_busy <= !cs_n_s;
         if (cs_n_s || !(state_reg == MFR_ST_DATA || state_reg == MFR_ST_DUMMY)) begin
            o_io_oe_n <= 4'hF;
         end else if (data_fall) begin
            o_io <= out_next;
            o_io_oe_n <= (cmd_reg == MFR_CMD_DIO) ? 4'hC : 4'h0;
         end
      end
   end

   a_deselect_idle: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      cs_n_s |=> state_reg == MFR_ST_IDLE)
      else $error("select high did not end read");
   a_dummy_no_drive: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      state_reg == MFR_ST_DUMMY && !data_fall |=> o_io_oe_n == 4'hF)
      else $error("lines driven in dummy");
   a_quad_gate: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      cmd_reg == MFR_CMD_QIO && state_reg == MFR_ST_ADDR && $changed(state_reg) |-> quad_ok)
      else $error("four-line read without enable");
   a_dual_lanes: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      state_reg == MFR_ST_DATA && cmd_reg == MFR_CMD_DIO && !o_io_oe_n[0] |-> o_io_oe_n[3:2] == 2'b11)
      else $error("two-line read drove upper lines");
   a_mode_reset: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      mrst_hit |=> cont_cmd_reg == MFR_CMD_NONE)
      else $error("mode reset ignored");
   a_cont_keep: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      cs_rise && state_reg == MFR_ST_DATA && cmd_reg == MFR_CMD_DIO && keep_reg
      |=> cont_cmd_reg == MFR_CMD_DIO)
      else $error("continuous two-line not kept");
   a_cont_leave: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      cs_rise && state_reg == MFR_ST_DATA && !keep_reg |=> cont_cmd_reg == MFR_CMD_NONE)
      else $error("continuous not left");
   a_addr_step: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      state_reg == MFR_ST_DATA && !cs_n_s && sck_fall && cmd_reg == MFR_CMD_OUT4 && bitpos_reg == 3'd3
      |=> addr_reg == $past(addr_reg) + 32'h1)
      else $error("address not stepped");
endmodule

// >>> tb/mfr_host_model.sv
`timescale 1ns/1ps
module mfr_host_model (
   // system
   input wire logic i_clk,
   // device side of the shared lines
   input wire logic [3:0] i_dev_io,
   input wire logic [3:0] i_dev_oe_n,
   // link pins
   output logic o_sck,
   output logic o_cs_n,
   output logic [3:0] o_io
);
   logic [3:0] drv_val;
   logic drv_en;
   logic [3:0] last_reg = 4'h0;
   initial begin
      o_sck = 1'b0;
      o_cs_n = 1'b1;
      drv_val = 4'h0;
      drv_en = 1'b0;
   end
   // a line nobody drives flips every clk so a stale value never looks valid
   always @(posedge i_clk) last_reg <= o_io;
   always_comb begin
      for (int b = 0; b < 4; b++) begin
         o_io[b] = !i_dev_oe_n[b] ? i_dev_io[b] : (drv_en ? drv_val[b] : ~last_reg[b]);
      end
   end
   // one link clock: low half, rise, sample late in the high half, fall
   task automatic cyc(input logic [3:0] v, input logic en, output logic [3:0] seen, output logic [3:0] oe);
      drv_val = v;
      drv_en = en;
      repeat (4) @(negedge i_clk);
      o_sck = 1'b1;
      repeat (3) @(negedge i_clk);
      seen = o_io;
      oe = i_dev_oe_n;
      @(negedge i_clk);
      o_sck = 1'b0;
   endtask
   task automatic shift(input logic [31:0] v, input int nbits, input int lanes);
      logic [3:0] s;
      logic [3:0] oe;
      for (int c = 0; c < nbits / lanes; c++) begin
         cyc(4'((v >> (nbits - (c + 1) * lanes)) & ((32'h1 << lanes) - 1)), 1'b1, s, oe);
      end
   endtask
   // junk the device must ignore, or lines released
   task automatic idle(input int n, input logic junk);
      logic [3:0] s;
      logic [3:0] oe;
      for (int c = 0; c < n; c++) begin
         cyc(4'h5 ^ {4{c[0]}}, junk, s, oe);
      end
   endtask
   task automatic get_byte(input int lanes, output logic [7:0] d, output logic [3:0] oe);
      logic [3:0] s;
      d = 8'h00;
      for (int c = 0; c < 8 / lanes; c++) begin
         cyc(4'h0, 1'b0, s, oe);
         d = 8'((d << lanes) | (s & 4'((32'h1 << lanes) - 1)));
      end
   endtask
   task automatic sel();
      o_cs_n = 1'b0;
      repeat (4) @(negedge i_clk);
   endtask
   // select rises four clk periods after the call, host drive released with it
   task automatic desel();
      repeat (4) @(negedge i_clk);
      o_cs_n = 1'b1;
      drv_en = 1'b0;
      repeat (8) @(negedge i_clk);
   endtask
endmodule

// >>> tb/tb_mfr_read_engine.sv
`timescale 1ns/1ps
module tb_mfr_read_engine;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic sck;
   logic cs_n;
   logic [3:0] io_in;
   logic [3:0] dev_io;
   logic [3:0] dev_oe_n;
   logic [3:0] lat_cfg = 4'h0;
   logic [7:0] cr1 = 8'h00;
   logic [7:0] cr2 = 8'h00;
   logic mem_we = 1'b0;
   logic [7:0] mem_waddr = 8'h00;
   logic [7:0] mem_wdata = 8'h00;
   logic cont;
   logic busy;
   int errors = 0;
   int n_checks = 0;
   always #12.5 clk = ~clk;
   mfr_read_engine #(.MEM_AW(8)) i_dut (
      .i_clk(clk), .i_rst_n(rst_n), .i_sck(sck), .i_cs_n(cs_n), .i_io(io_in), .o_io(dev_io),
      .o_io_oe_n(dev_oe_n), .i_latency_config_reg(lat_cfg), .i_config_reg1_volatile(cr1),
      .i_config_reg2_volatile(cr2), .i_mem_we(mem_we), .i_mem_waddr(mem_waddr), .i_mem_wdata(mem_wdata),
      .o_cont_active(cont), .o_busy(busy));
   mfr_host_model i_host (
      .i_clk(clk), .i_dev_io(dev_io), .i_dev_oe_n(dev_oe_n), .o_sck(sck), .o_cs_n(cs_n), .o_io(io_in));
   function automatic logic [7:0] pat(input logic [7:0] a);
      return a ^ 8'h5A;
   endfunction
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic test_done();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // ol/al/dl: instruction, address and data lanes; ol 0 means no instruction
   task automatic xfer(input logic [7:0] op, input int ol, input int al, input int ab, input logic [31:0] addr,
         input int dl, input logic [3:0] mode, input int lat, input int nb);
      logic [7:0] d;
      logic [3:0] oe;
      lat_cfg = 4'(lat);
      i_host.sel();
      if (ol > 0) i_host.shift({24'h0, op}, 8, ol);
      i_host.shift(addr, ab, al);
      if (al > 1) begin
         i_host.shift({28'h0, mode}, 4, al);
         i_host.idle(4 / al, 1'b0);
      end
      if (lat > 0) begin
         i_host.idle(lat - 1, 1'b1);
         i_host.idle(1, 1'b0);
      end
      for (int k = 0; k < nb; k++) begin
         i_host.get_byte(dl, d, oe);
         chk("data", d, pat(8'(addr[7:0] + k)));
         chk("oe_n data", {4'h0, oe}, (dl == 4) ? 8'h00 : 8'h0C);
      end
      i_host.desel();
      chk("oe_n idle", {4'h0, dev_oe_n}, 8'h0F);
      chk("busy idle", {7'h0, busy}, 8'h00);
   endtask
   task automatic t_out_read();
      cr2 = 8'h00;
      xfer(8'h6B, 1, 1, 24, 32'h000012FE, 4, 4'h0, 3, 4);
   endtask
   task automatic t_wide();
      cr2 = 8'h01;
      xfer(8'h6B, 1, 1, 32, 32'hABCD0040, 4, 4'h0, 0, 2);
      cr2 = 8'h00;
      xfer(8'h6C, 1, 1, 32, 32'h00000081, 4, 4'h0, 1, 2);
   endtask
   task automatic t_dio();
      xfer(8'hBB, 1, 2, 24, 32'h00000033, 2, 4'hA, 2, 3);
      chk("cont", {7'h0, cont}, 8'h01);
      xfer(8'h00, 0, 2, 24, 32'h00000070, 2, 4'h5, 1, 2);
      chk("cont", {7'h0, cont}, 8'h00);
      xfer(8'hBC, 1, 2, 32, 32'h112233F0, 2, 4'h0, 0, 2);
   endtask
   task automatic t_qio();
      logic [7:0] d;
      logic [3:0] oe;
      cr1 = 8'h00;
      lat_cfg = 4'h1;
      i_host.sel();
      i_host.shift(32'hEB, 8, 1);
      i_host.shift(32'h10, 24, 4);
      i_host.idle(3, 1'b0);
      i_host.get_byte(4, d, oe);
      chk("oe_n refused", {4'h0, oe}, 8'h0F);
      i_host.desel();
      chk("cont", {7'h0, cont}, 8'h00);
      cr1 = 8'h02;
      xfer(8'hEB, 1, 4, 24, 32'h00000010, 4, 4'hA, 4, 2);
      chk("cont", {7'h0, cont}, 8'h01);
      xfer(8'h00, 0, 4, 24, 32'h000000FF, 4, 4'hA, 2, 2);
      chk("cont", {7'h0, cont}, 8'h01);
      i_host.sel();
      i_host.shift(32'hFFFFFFFF, 32, 4);
      i_host.desel();
      chk("cont", {7'h0, cont}, 8'h00);
      xfer(8'hEC, 1, 4, 32, 32'h0A0B0C37, 4, 4'h0, 2, 2);
      cr1 = 8'h00;
   endtask
   task automatic t_quad_instr();
      cr2 = 8'h0A;
      xfer(8'hEB, 4, 4, 24, 32'h000000C8, 4, 4'h0, 1, 2);
      cr2 = 8'h00;
   endtask
   initial begin
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      for (int a = 0; a < 256; a++) begin
         @(negedge clk);
         mem_we = 1'b1;
         mem_waddr = 8'(a);
         mem_wdata = pat(8'(a));
      end
      @(negedge clk);
      mem_we = 1'b0;
      t_out_read();
      t_wide();
      t_dio();
      t_qio();
      t_quad_instr();
      test_done();
   end
   initial begin
      #1_000_000;
      errors++;
      test_done();
   end
endmodule
